//--- src/cief_core.sv
// cief_core: main interrupt enable and flag register with request gating
// assumes: timer overflow arrives as a one-cycle pulse, other flags are held by their sources; core polls over the register port
//
// Operation
// RULE1 - with priority mode off, bit 7 is a master gate over all unmasked sources.
// RULE2 - with priority mode on, bit 7 gates all enabled high-priority sources.
// RULE3 - bit 5 enables the timer zero overflow request.
// RULE4 - bit 4 enables the external pin zero request.
// RULE5 - bit 3 enables the port-b change request.
// RULE6 - bit 2 is the overflow flag, set by hardware and cleared only by software.
// RULE7 - with priority mode off, bit 6 collectively gates peripheral sources.
// RULE8 - with priority mode on, bit 6 gates all enabled low-priority sources.
// RULE9 - flags set on their events regardless of any enable bit.
// RULE10 - a separate priority mode bit, clear after reset, makes priority bits inert.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cief_core
  import cief_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register port
  input wire cief_req_t req_in,
  output logic [7:0] rdata_out,
  // event sources and their flags held elsewhere
  input wire logic tmr_ovf_in,
  input wire logic ext_pin_flag_in,
  input wire logic pb_change_flag_in,
  input wire logic periph_req_in,
  // per-source priority, high when set
  input wire logic tmr_prio_in,
  input wire logic ext_prio_in,
  input wire logic pb_prio_in,
  input wire logic periph_prio_in,
  // requests toward the core
  output logic high_req_out,
  output logic low_req_out,
  output logic irq_out
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] main_q;
  logic prio_mode_q;
  logic [CIEF_NUM_EVT-1:0] stat_q;
  logic [CIEF_NUM_EVT-1:0] mask_q;
  logic [7:0] rdata_q;
  logic high_q;
  logic low_q;
  logic irq_q;
  cief_level_t level_q;

  logic wr_main;
  logic tmr_src;
  logic ext_src;
  logic pb_src;
  logic hi_any;
  logic lo_any;
  logic high_d;
  logic low_d;
  logic [CIEF_NUM_EVT-1:0] rise;

  assign wr_main = req_in.wr && (req_in.addr == CIEF_ADDR_CTRL_MAIN);

  // enabled sources, a flag only counts when its enable bit is set
  assign tmr_src = main_q[CIEF_BIT_TMR_IF] && main_q[CIEF_BIT_TMR_IE]; // RULE3
  assign ext_src = ext_pin_flag_in && main_q[CIEF_BIT_EXT_IE]; // RULE4
  assign pb_src = pb_change_flag_in && main_q[CIEF_BIT_PB_IE]; // RULE5

  // priority bits only count when priority mode is on
  always_comb
  begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    high_d = 1'b0;
    low_d = 1'b0;
    if (prio_mode_q)
    begin
      hi_any = (tmr_src && tmr_prio_in) || (ext_src && ext_prio_in)
        || (pb_src && pb_prio_in) || (periph_req_in && periph_prio_in);
      lo_any = (tmr_src && !tmr_prio_in) || (ext_src && !ext_prio_in)
        || (pb_src && !pb_prio_in) || (periph_req_in && !periph_prio_in);
      high_d = hi_any && main_q[CIEF_BIT_GLOBAL]; // RULE2
      low_d = lo_any && main_q[CIEF_BIT_SECOND]; // RULE8
    end
    else
    begin
      // core sources need only bit 7, peripherals need bit 6 as well
      hi_any = tmr_src || ext_src || pb_src
        || (periph_req_in && main_q[CIEF_BIT_SECOND]); // RULE7 RULE10
      high_d = hi_any && main_q[CIEF_BIT_GLOBAL]; // RULE1
    end
  end

  // ----------------------------------------
  // main register: enables written, overflow flag sticky
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      main_q <= CIEF_MAIN_RESET;
    else
    begin
      if (wr_main)
        main_q <= req_in.wdata;
      // overflow wins over a same-cycle software clear
      if (tmr_ovf_in)
        main_q[CIEF_BIT_TMR_IF] <= 1'b1; // RULE6 RULE9
    end
  end

  // priority mode bit, clear after reset
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      prio_mode_q <= CIEF_AUX_RESET[0]; // RULE10
    else if (req_in.wr && (req_in.addr == CIEF_ADDR_CTRL_AUX))
      prio_mode_q <= req_in.wdata[0];
  end

  // request outputs registered so the core sees glitch-free levels
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      high_q <= 1'b0;
      low_q <= 1'b0;
    end
    else
    begin
      high_q <= high_d;
      low_q <= low_d;
    end
  end

  // current granted level, used to detect new requests
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      level_q <= CIEF_IDLE;
    else
    begin
      case ({high_d, low_d})
        2'b10, 2'b11: level_q <= CIEF_HIGH;
        2'b01: level_q <= CIEF_LOW;
        default: level_q <= CIEF_IDLE;
      endcase
    end
  end

  // rising request edges, per event bit
  assign rise[0] = high_d && (level_q != CIEF_HIGH);
  assign rise[1] = low_d && !high_d && (level_q != CIEF_LOW);

  // ----------------------------------------
  // sticky event status and mask
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CIEF_NUM_EVT; gi++)
    begin : g_evt
      always_ff @(posedge clk_in)
      begin
        if (!rstn_in)
          stat_q[gi] <= 1'b0;
        else if (rise[gi])
          stat_q[gi] <= 1'b1; // set beats the read clear
        else if (req_in.rd && (req_in.addr == CIEF_ADDR_EVT_STAT))
          stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      mask_q <= '0;
    else if (req_in.wr && (req_in.addr == CIEF_ADDR_EVT_MASK))
      mask_q <= req_in.wdata[CIEF_NUM_EVT-1:0];
  end

  // level interrupt; one cycle behind status by design
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

  // ----------------------------------------
  // read data, valid the cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      rdata_q <= 8'h00;
    else if (req_in.rd)
    begin
      case (req_in.addr)
        CIEF_ADDR_CTRL_MAIN: rdata_q <= main_q;
        CIEF_ADDR_CTRL_AUX: rdata_q <= {7'h00, prio_mode_q};
        CIEF_ADDR_EVT_STAT: rdata_q <= {6'h00, stat_q};
        CIEF_ADDR_EVT_MASK: rdata_q <= {6'h00, mask_q};
        default: rdata_q <= 8'h00; // unmapped reads as zero
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign rdata_out = rdata_q;
  assign high_req_out = high_q;
  assign low_req_out = low_q;
  assign irq_out = irq_q;

endmodule : cief_core
`default_nettype wire

//--- src/cief_pkg.sv
// cief_pkg: constants and types for the core interrupt enable/flag block
// assumes: one 200 MHz clock, plain register port with one-cycle read latency
package cief_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] CIEF_ADDR_CTRL_MAIN = 4'h0; // main enable/flag register
  localparam logic [3:0] CIEF_ADDR_CTRL_AUX = 4'h1;  // priority mode enable
  localparam logic [3:0] CIEF_ADDR_EVT_STAT = 4'h2;  // sticky event status, read clears
  localparam logic [3:0] CIEF_ADDR_EVT_MASK = 4'h3;  // event mask

  // ----------------------------------------
  // field positions of interrupt_control_main
  // ----------------------------------------
  localparam int CIEF_BIT_GLOBAL = 7;
  localparam int CIEF_BIT_SECOND = 6;
  localparam int CIEF_BIT_TMR_IE = 5;
  localparam int CIEF_BIT_EXT_IE = 4;
  localparam int CIEF_BIT_PB_IE = 3;
  localparam int CIEF_BIT_TMR_IF = 2;

  // ----------------------------------------
  // reset values and event status layout
  // ----------------------------------------
  localparam logic [7:0] CIEF_MAIN_RESET = 8'h00;
  localparam logic [7:0] CIEF_AUX_RESET = 8'h00;
  localparam int CIEF_NUM_EVT = 2; // bit0 high request rises, bit1 low request rises

  // request gating state
  typedef enum logic [1:0] {CIEF_IDLE, CIEF_HIGH, CIEF_LOW} cief_level_t;

  // register port request bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cief_req_t;

endpackage : cief_pkg

//--- tb/cief_src.sv
// cief_src: overflow source in place of the timer zero counter
// assumes: fire_in changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cief_src (
  // clock
  input wire logic clk_in,
  // request in, overflow pulse out
  input wire logic fire_in,
  output logic ovf_out
);
  logic seen_q;
  // edge detect: a held request still makes one overflow
  always_ff @(posedge clk_in) seen_q <= fire_in;
  assign ovf_out = fire_in && !seen_q;
endmodule : cief_src
`default_nettype wire

//--- tb/cief_checker.sv
// cief_checker: port-level checks on the enable/flag block
// assumes: bound into cief_core, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module cief_checker
  import cief_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register port
  input wire cief_req_t req_in,
  input wire logic [7:0] rdata_out,
  // sources
  input wire logic tmr_ovf_in,
  input wire logic ext_pin_flag_in,
  input wire logic pb_change_flag_in,
  input wire logic periph_req_in,
  input wire logic tmr_prio_in,
  input wire logic ext_prio_in,
  input wire logic pb_prio_in,
  input wire logic periph_prio_in,
  // requests
  input wire logic high_req_out,
  input wire logic low_req_out,
  input wire logic irq_out
);
  logic [7:0] main_q;
  logic mode_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // shadow registers; overflow set wins over a same-cycle write
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      main_q <= 8'h00;
      mode_q <= 1'b0;
    end
    else
    begin
      if (req_in.wr && req_in.addr == CIEF_ADDR_CTRL_MAIN) main_q <= req_in.wdata;
      if (tmr_ovf_in) main_q[2] <= 1'b1;
      if (req_in.wr && req_in.addr == CIEF_ADDR_CTRL_AUX) mode_q <= req_in.wdata[0];
    end
  end
  master_gate_a: assert property (!mode_q && !main_q[7] |=> !high_req_out)
    else $error("request with master off");
  high_gate_a: assert property (mode_q && !main_q[7] |=> !high_req_out)
    else $error("high request gated off");
  low_gate_a: assert property (mode_q && !main_q[6] |=> !low_req_out)
    else $error("low request gated off");
  compat_low_a: assert property (!mode_q |=> !low_req_out)
    else $error("low request in compat mode");
  tmr_req_a: assert property (!mode_q && main_q[7] && main_q[5] && main_q[2] |=> high_req_out)
    else $error("overflow request missing");
  ext_req_a: assert property (!mode_q && main_q[7] && main_q[4] && ext_pin_flag_in |=> high_req_out)
    else $error("pin request missing");
  pb_req_a: assert property (!mode_q && main_q[7] && main_q[3] && pb_change_flag_in |=> high_req_out)
    else $error("change request missing");
  peri_req_a: assert property (!mode_q && main_q[7] && main_q[6] && periph_req_in |=> high_req_out)
    else $error("peripheral request missing");
  flag_read_a: assert property (req_in.rd && req_in.addr == 4'h0 |=> rdata_out == $past(main_q))
    else $error("main readback wrong");
endmodule : cief_checker
bind cief_core cief_checker u_chk (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .req_in(req_in),
  .rdata_out(rdata_out),
  .tmr_ovf_in(tmr_ovf_in),
  .ext_pin_flag_in(ext_pin_flag_in),
  .pb_change_flag_in(pb_change_flag_in),
  .periph_req_in(periph_req_in),
  .tmr_prio_in(tmr_prio_in),
  .ext_prio_in(ext_prio_in),
  .pb_prio_in(pb_prio_in),
  .periph_prio_in(periph_prio_in),
  .high_req_out(high_req_out),
  .low_req_out(low_req_out),
  .irq_out(irq_out)
);
`default_nettype wire

//--- tb/cief_core_tb_top.sv
// cief_core_tb_top: directed bench for the enable/flag block
// assumes: cief_src drives the overflow input
`timescale 1ns/1ps
`default_nettype none
module cief_core_tb_top
  import cief_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic fire = 1'b0;
  logic ext = 1'b0;
  logic pb = 1'b0;
  logic per = 1'b0;
  logic [3:0] pr = 4'h0;
  cief_req_t req = '0;
  logic [7:0] rdata;
  logic ovf, hi, lo, irq;
  int mismatches = 0;
  int checks_done = 0;
  initial forever #2.5 clk_in = ~clk_in;
  cief_src src (.clk_in(clk_in), .fire_in(fire), .ovf_out(ovf));
  cief_core uut (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
    .tmr_ovf_in(ovf), .ext_pin_flag_in(ext), .pb_change_flag_in(pb), .periph_req_in(per),
    .tmr_prio_in(pr[0]), .ext_prio_in(pr[1]), .pb_prio_in(pr[2]), .periph_prio_in(pr[3]),
    .high_req_out(hi), .low_req_out(lo), .irq_out(irq));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in) req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in) req <= '0;
    #1 chk(rdata, e);
  endtask : rd
  // outputs settle two cycles after a write; three leaves margin
  task automatic st(input logic [2:0] e);
    repeat (3) @(posedge clk_in);
    #1 chk(8'({irq, lo, hi}), 8'(e));
  endtask : st
  task automatic t_compat();
    rd(4'h1, 8'h00);
    @(posedge clk_in) fire <= 1'b1;
    @(posedge clk_in) fire <= 1'b0;
    st(3'b000);
    rd(4'h0, 8'h04);
    wr(4'h0, 8'ha4);
    st(3'b001);
    wr(4'h0, 8'h84);
    st(3'b000);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h80);
    rd(4'hf, 8'h00);
  endtask : t_compat
  task automatic t_srcs();
    // priority bits all set: compat mode must ignore them
    @(posedge clk_in) {ext, pr} <= 5'h1f;
    wr(4'h0, 8'h90);
    st(3'b001);
    @(posedge clk_in) {ext, pb} <= 2'b01;
    st(3'b000);
    wr(4'h0, 8'h88);
    st(3'b001);
    @(posedge clk_in) {pb, per} <= 2'b01;
    wr(4'h0, 8'h80);
    st(3'b000);
    wr(4'h0, 8'hc0);
    st(3'b001);
  endtask : t_srcs
  task automatic t_prio();
    @(posedge clk_in) {per, ext, pr} <= 6'h12;
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h01);
    wr(4'h0, 8'h10);
    st(3'b000);
    wr(4'h0, 8'h90);
    st(3'b001);
    @(posedge clk_in) pr <= 4'h0;
    wr(4'h0, 8'h50);
    st(3'b010);
    wr(4'h0, 8'h10);
    st(3'b000);
  endtask : t_prio
  // sticky status, mask, read clear, masked rise
  task automatic t_irq();
    wr(4'h3, 8'h03);
    st(3'b100);
    rd(4'h2, 8'h03);
    st(3'b000);
    wr(4'h3, 8'h02);
    rd(4'h3, 8'h02);
    @(posedge clk_in) pr <= 4'h2;
    wr(4'h0, 8'h90);
    st(3'b001);
    rd(4'h2, 8'h01);
  endtask : t_irq
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_compat();
    t_srcs();
    t_prio();
    t_irq();
    tally_and_finish();
  end
  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
endmodule : cief_core_tb_top
`default_nettype wire
